// *** logic/sbg_regs.svh ***
// register offsets, field positions and reset values of the baud rate generator
// assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register
// ----------------------------------------
// ----------------------------------------
`ifndef SBG_REGS_SVH
`define SBG_REGS_SVH

`define SBG_CKSTP_OFS    8'h00
`define SBG_DIV0_OFS     8'h04
`define SBG_FMT0_OFS     8'h08
`define SBG_DIV1_OFS     8'h0c
`define SBG_FMT1_OFS     8'h10
`define SBG_STAT_OFS     8'h14

`define SBG_CKSTP_RST    8'hff
`define SBG_DIV_RST      8'hff
`define SBG_FMT_RST      3'h0
`define SBG_FMT_SYNC_BIT 7
`define SBG_STBY_CH0_BIT 6
`define SBG_STBY_CH1_BIT 5

`define SBG_ASYNC_LAST   6'h3f
`define SBG_SYNC_LAST    6'h07
`define SBG_PRE16_LAST   4'hf
`define SBG_PRE64_LAST   6'h3f

`define SBG_RESP_OKAY    2'b00
`define SBG_RESP_SLVERR  2'b10

`endif

// *** logic/sbg_pkg.sv ***
// types shared by the baud rate generator
// assumes nothing beyond the register header
package sbg_pkg;
  typedef enum logic [1:0] {
    SBG_CKS_PHI = 2'b00,
    SBG_CKS_SUB = 2'b01,
    SBG_CKS_16  = 2'b10,
    SBG_CKS_64  = 2'b11
  } sbg_cks_e;

  typedef struct packed {
    logic     sync_mode;
    sbg_cks_e cks;
  } sbg_cfg_s;

  typedef enum logic [2:0] {
    SBG_R_CKSTP, SBG_R_DIV0, SBG_R_FMT0, SBG_R_DIV1, SBG_R_FMT1, SBG_R_STAT, SBG_R_NONE
  } sbg_reg_e;
endpackage : sbg_pkg

// *** logic/sbg_top.sv ***
// two-channel baud rate generator with module standby control
// assumes aclk is the system clock phi and subclk_in is synchronous to it
//
// Implementation choices: the address map and the AXI4-Lite register port.
`include "sbg_regs.svh"

module sbg_top
  import sbg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              subclk_in,
  input  wire logic              sub_mode,
  input  wire logic              standby_in,
  output logic [1:0]             baud_tick,
  output logic [1:0]             chan_run
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]        ckstp_reg;
  logic [7:0]        div_reg [2];
  sbg_cfg_s          fmt_reg [2];
  sbg_cfg_s          act_cfg_reg [2];
  logic [7:0]        cnt_reg [2];
  logic [5:0]        frac_reg [2];
  logic [1:0]        tick_reg;
  logic [1:0]        run_reg;
  logic [5:0]        pre_reg;
  logic              subclk_q_reg;
  logic              sub_half_reg;
  logic              aw_got_reg, w_got_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       rdata_reg;

  logic              aw_got_next, w_got_next, bvalid_next, rvalid_next, do_write;
  logic              t16, t64, sub_rise, sub_tick;
  logic [1:0]        src_tick, mstby;
  sbg_reg_e          wsel;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic sbg_reg_e reg_decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`SBG_CKSTP_OFS)) reg_decode = SBG_R_CKSTP;
    else if (a == ADDR_W'(`SBG_DIV0_OFS)) reg_decode = SBG_R_DIV0;
    else if (a == ADDR_W'(`SBG_FMT0_OFS)) reg_decode = SBG_R_FMT0;
    else if (a == ADDR_W'(`SBG_DIV1_OFS)) reg_decode = SBG_R_DIV1;
    else if (a == ADDR_W'(`SBG_FMT1_OFS)) reg_decode = SBG_R_FMT1;
    else if (a == ADDR_W'(`SBG_STAT_OFS)) reg_decode = SBG_R_STAT;
    else reg_decode = SBG_R_NONE;
  endfunction : reg_decode

  function automatic logic src_pick(input sbg_cks_e k, input logic p16, input logic p64, input logic ps);
    case (k)
      SBG_CKS_PHI: src_pick = 1'b1;
      SBG_CKS_SUB: src_pick = ps;
      SBG_CKS_16:  src_pick = p16;
      default:     src_pick = p64;
    endcase
  endfunction : src_pick

  function automatic logic [5:0] frac_last(input sbg_cfg_s f);
    frac_last = f.sync_mode ? `SBG_SYNC_LAST : `SBG_ASYNC_LAST;
  endfunction : frac_last

  function automatic logic [7:0] fmt_byte(input sbg_cfg_s f);
    fmt_byte = {f.sync_mode, 5'h00, f.cks};
  endfunction : fmt_byte

  // ----------------------------------------
  // prescaler and subclock path
  // ----------------------------------------
  assign t16      = pre_reg[3:0] == `SBG_PRE16_LAST;
  assign t64      = pre_reg == `SBG_PRE64_LAST;
  assign sub_rise = subclk_in & ~subclk_q_reg;
  // half rate outside the sub modes, full subclock inside them
  assign sub_tick = sub_rise & (sub_mode | sub_half_reg);
  assign mstby[0] = ~ckstp_reg[`SBG_STBY_CH0_BIT];
  assign mstby[1] = ~ckstp_reg[`SBG_STBY_CH1_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg      <= 6'h00;
      subclk_q_reg <= 1'b0;
      sub_half_reg <= 1'b0;
    end else begin
      pre_reg      <= pre_reg + 6'h01;
      subclk_q_reg <= subclk_in;
      if (sub_rise) begin
        sub_half_reg <= ~sub_half_reg;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      src_tick[c] = src_pick(act_cfg_reg[c].cks, t16, t64, sub_tick);
    end
  end

  // ----------------------------------------
  // divider channels
  // ----------------------------------------
  // cfg is sampled at every divider reload, so a write can cut the bit period in progress short
  always_ff @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      if (!aresetn || mstby[c]) begin
        cnt_reg[c]     <= 8'h00;
        frac_reg[c]    <= 6'h00;
        act_cfg_reg[c] <= `SBG_FMT_RST;
        tick_reg[c]    <= 1'b0;
      end else begin
        tick_reg[c] <= 1'b0;
        if (src_tick[c]) begin
          if (cnt_reg[c] == 8'h00) begin
            cnt_reg[c]     <= div_reg[c];
            act_cfg_reg[c] <= fmt_reg[c];
            if (frac_reg[c] >= frac_last(act_cfg_reg[c])) begin
              frac_reg[c] <= 6'h00;
              tick_reg[c] <= 1'b1;
            end else begin
              frac_reg[c] <= frac_reg[c] + 6'h01;
            end
          end else begin
            cnt_reg[c] <= cnt_reg[c] - 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= 2'b11;
    end else begin
      run_reg <= ~mstby;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  assign wsel = reg_decode(aw_addr_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ckstp_reg <= `SBG_CKSTP_RST;
    end else if (do_write && wsel == SBG_R_CKSTP && w_strb_reg[0]) begin
      ckstp_reg <= w_data_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      if (!aresetn || mstby[c] || standby_in) begin
        div_reg[c] <= `SBG_DIV_RST;
      end else if (do_write && w_strb_reg[0] && wsel == (c == 0 ? SBG_R_DIV0 : SBG_R_DIV1)) begin
        div_reg[c] <= w_data_reg[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      if (!aresetn || mstby[c]) begin
        fmt_reg[c] <= `SBG_FMT_RST;
      end else if (do_write && w_strb_reg[0] && wsel == (c == 0 ? SBG_R_FMT0 : SBG_R_FMT1)) begin
        fmt_reg[c] <= {w_data_reg[`SBG_FMT_SYNC_BIT], sbg_cks_e'(w_data_reg[1:0])};
      end
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  // aw and w are taken independently; the write lands once both are held
  assign do_write    = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign aw_got_next = (aw_got_reg & ~do_write) | (awvalid & awready_reg);
  assign w_got_next  = (w_got_reg & ~do_write) | (wvalid & wready_reg);
  assign bvalid_next = do_write | (bvalid_reg & ~bready);
  assign rvalid_next = (arvalid & arready_reg) | (rvalid_reg & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SBG_RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      awready_reg <= ~aw_got_next & ~bvalid_next;
      wready_reg  <= ~w_got_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (awvalid && awready_reg) begin
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        bresp_reg <= (wsel == SBG_R_NONE || wsel == SBG_R_STAT) ? `SBG_RESP_SLVERR : `SBG_RESP_OKAY;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `SBG_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (arvalid && arready_reg) begin
        rresp_reg <= `SBG_RESP_OKAY;
        case (reg_decode(araddr))
          SBG_R_CKSTP: rdata_reg <= {24'h000000, ckstp_reg};
          SBG_R_DIV0:  rdata_reg <= {24'h000000, div_reg[0]};
          SBG_R_FMT0:  rdata_reg <= {24'h000000, fmt_byte(fmt_reg[0])};
          SBG_R_DIV1:  rdata_reg <= {24'h000000, div_reg[1]};
          SBG_R_FMT1:  rdata_reg <= {24'h000000, fmt_byte(fmt_reg[1])};
          SBG_R_STAT:  rdata_reg <= {16'h0000, cnt_reg[1], cnt_reg[0]};
          default: begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SBG_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  assign awready   = awready_reg;
  assign wready    = wready_reg;
  assign bvalid    = bvalid_reg;
  assign bresp     = bresp_reg;
  assign arready   = arready_reg;
  assign rvalid    = rvalid_reg;
  assign rdata     = rdata_reg;
  assign rresp     = rresp_reg;
  assign baud_tick = tick_reg;
  assign chan_run  = run_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_term0;
    src_tick[0] && cnt_reg[0] == 8'h00 && !mstby[0];
  endsequence
  sequence s_async_wrap0;
    s_term0 ##0 !act_cfg_reg[0].sync_mode && frac_reg[0] == `SBG_ASYNC_LAST;
  endsequence
  sequence s_sync_wrap0;
    s_term0 ##0 act_cfg_reg[0].sync_mode && frac_reg[0] == `SBG_SYNC_LAST;
  endsequence

  async_wrap_a: assert property (s_async_wrap0 |=> baud_tick[0]) else $error("async tick missing");
  sync_wrap_a: assert property (s_sync_wrap0 |=> baud_tick[0]) else $error("sync tick missing");
  div_reload_a: assert property (s_term0 |=> cnt_reg[0] == $past(div_reg[0])) else $error("bad reload");
  // no reload at the trigger, so the source select cannot change under the check
  pre64_gap_a: assert property (src_tick[0] && act_cfg_reg[0].cks == SBG_CKS_64 && !mstby[0]
    && cnt_reg[0] != 8'h00 |=> (!src_tick[0] || mstby[0]) [*8]) else $error("phi/64 too fast");
  sub_full_a: assert property (sub_mode && sub_rise && act_cfg_reg[0].cks == SBG_CKS_SUB
    |-> src_tick[0]) else $error("subclock edge lost");
  // stepwise form: a later register write cannot trip it
  max_rate_a: assert property (src_tick[0] && act_cfg_reg[0] == `SBG_FMT_RST && cnt_reg[0] == 8'h00
    && div_reg[0] == 8'h00 && frac_reg[0] != `SBG_ASYNC_LAST && !mstby[0]
    |=> cnt_reg[0] == 8'h00 && frac_reg[0] == $past(frac_reg[0]) + 6'h01)
    else $error("max rate step wrong");
  stby_clear_a: assert property (mstby[0] |=> div_reg[0] == `SBG_DIV_RST && cnt_reg[0] == 8'h00
    && !baud_tick[0]) else $error("standby not cleared");
  run_follow_a: assert property (##1 chan_run == {ckstp_reg[`SBG_STBY_CH1_BIT], ckstp_reg[`SBG_STBY_CH0_BIT]}
    || $changed(ckstp_reg)) else $error("run output stale");
  count_down_a: assert property (src_tick[0] && cnt_reg[0] != 8'h00 && !mstby[0]
    |=> cnt_reg[0] == $past(cnt_reg[0]) - 8'h01) else $error("counter skipped");
  ckstp_reset_a: assert property ($rose(aresetn) |-> ckstp_reg == `SBG_CKSTP_RST)
    else $error("clock stop reset value");

endmodule : sbg_top

// *** verification/sbg_tb_top.sv ***
// bench for the two-channel baud rate generator: registers, rates, standby
// assumes sbg_pkg and sbg_regs.svh are compiled ahead of it, aclk at 100 MHz
`include "sbg_regs.svh"

module serial_baud_rate_generator_tb_top
  import sbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, baud_tick, chan_run, sc;
  logic        subclk_in, sub_mode, standby_in;
  int          failures, n_checks, seed, cyc;

  sbg_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
                 .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
                 .rready, .subclk_in, .sub_mode, .standby_in, .baud_tick, .chan_run);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // free-running subclock, one rising edge every 4 cycles
  always @(posedge aclk) begin
    sc <= sc + 2'd1;
    subclk_in <= sc[1];
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      failures = failures + 1;
      conclude();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah;
    logic wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge aclk);
      ah = ah | (awready === 1'b1);
      wh = wh | (wready === 1'b1);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // every rate is an exact division of aclk, so no rate error arises
  task automatic cfg(input int c, input logic sy, input logic [1:0] ck, input logic [7:0] v);
    logic [1:0] r;
    wr(c ? `SBG_FMT1_OFS : `SBG_FMT0_OFS, {24'h0, sy, 5'h0, ck}, r);
    wr(c ? `SBG_DIV1_OFS : `SBG_DIV0_OFS, {24'h0, v}, r);
  endtask : cfg

  // first interval may mix old and new settings, so the second one counts
  task automatic period(input int c, output int p);
    do @(posedge aclk); while (baud_tick[c] !== 1'b1);
    repeat (2) begin
      p = 0;
      do begin
        @(posedge aclk);
        p++;
      end while (baud_tick[c] !== 1'b1);
    end
  endtask : period

  function automatic int expp(input logic sy, input logic [1:0] ck, input logic [7:0] v, input logic sm);
    int pre;
    case (ck)
      2'b00:   pre = 1;
      2'b01:   pre = sm ? 4 : 8;
      2'b10:   pre = 16;
      default: pre = 64;
    endcase
    return (sy ? 8 : 64) * (v + 1) * pre;
  endfunction : expp

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int          p;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  ck;
    logic [7:0]  v;
    failures = 0;
    n_checks = 0;
    seed = 16;
    cyc = 0;
    sc = 2'd0;
    subclk_in = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, sub_mode, standby_in} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(chan_run, 2'b11, "run after reset");
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, (i == 2 || i == 4) ? 32'h0 : 32'hff, "reset value");
    end
    rd(8'h20, d, r);
    chk(r, `SBG_RESP_SLVERR, "unmapped read");
    wr(`SBG_STAT_OFS, 32'h0, r);
    chk(r, `SBG_RESP_SLVERR, "status write");
    $display("test reset and map done");

    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      wr(`SBG_DIV0_OFS, {24'h0, v}, r);
      rd(`SBG_DIV0_OFS, d, r);
      chk(d, {24'h0, v}, "divisor readback");
    end
    $display("test divisor range done");

    // channel 2 set early: its long reset-rate interval runs out meanwhile
    cfg(1, 1'b1, 2'b00, 8'hff);
    // slow prescales get tiny divisors to keep the run short
    for (int i = 0; i < 6; i++) begin
      ck = (i < 2) ? 2'b00 : (i < 4) ? 2'b10 : 2'b11;
      v = (i == 0) ? 8'h00 : 8'($random(seed)) & ((ck == 2'b00) ? 8'h07 : 8'h01);
      cfg(0, i[0], ck, v);
      rd(`SBG_FMT0_OFS, d, r);
      chk(d, {24'h0, i[0], 5'h0, ck}, "format readback");
      period(0, p);
      chk(p, expp(i[0], ck, v, 1'b0), "bit period");
    end
    // sub modes are entered only with the subclock path selected
    for (int i = 0; i < 2; i++) begin
      sub_mode <= i[0];
      cfg(0, i[0], 2'b01, 8'h00);
      period(0, p);
      chk(p, expp(i[0], 2'b01, 8'h00, i[0]), "subclock period");
    end
    period(1, p);
    chk(p, expp(1'b1, 2'b00, 8'hff, 1'b0), "channel 2 period");
    $display("test rates done");

    wr(`SBG_CKSTP_OFS, 32'hbf, r);
    repeat (2) @(posedge aclk);
    chk(chan_run, 2'b10, "channel 1 standby");
    rd(`SBG_DIV0_OFS, d, r);
    chk(d, 32'hff, "divisor in standby");
    rd(`SBG_FMT0_OFS, d, r);
    chk(d, 32'h0, "format in standby");
    wr(`SBG_DIV0_OFS, 32'h12, r);
    rd(`SBG_DIV0_OFS, d, r);
    chk(d, 32'hff, "write lost in standby");
    n = 0;
    repeat (200) begin
      @(posedge aclk);
      if (baud_tick[0] !== 1'b0) n++;
    end
    chk(n, 0, "no ticks in standby");
    wr(`SBG_CKSTP_OFS, 32'hdf, r);
    repeat (2) @(posedge aclk);
    chk(chan_run, 2'b01, "channel 2 standby");
    rd(`SBG_DIV1_OFS, d, r);
    chk(d, 32'hff, "channel 2 divisor cleared");
    v = 8'($random(seed));
    wr(`SBG_CKSTP_OFS, {24'h0, v}, r);
    rd(`SBG_CKSTP_OFS, d, r);
    chk(d, {24'h0, v}, "stop register readback");
    wr(`SBG_CKSTP_OFS, 32'hff, r);
    $display("test module standby done");

    wr(`SBG_DIV0_OFS, 32'h33, r);
    standby_in <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`SBG_DIV0_OFS, d, r);
    chk(d, 32'hff, "divisor in chip standby");
    standby_in <= 1'b0;
    $display("test chip standby done");
    conclude();
  end
endmodule : serial_baud_rate_generator_tb_top
